// file: child_count_decrement_leaf_regs.svh
// constants of the child-page counter decrement leaf
// assumes a 100 MHz core clock and a 48-bit canonical linear space
// Summary of operation
// - leaf index 00H selects decrement; needs feature bit EAX[5], both modes
// - refuse the operation unless current privilege level is 0
// - both linear addresses use data segment; overrides are ignored
// - target is read/write non-enclave access; control page enclave read
// - 32-bit mode: operand beyond data segment limit gives protection fault
// - 32-bit mode: unusable data segment gives protection fault
// - 64-bit mode: non-canonical operand address gives protection fault
// - target address not 4K aligned gives protection fault
// - translation or access fault on either operand gives page fault
// - page fault unless target is valid regular, thread, trimmed or control page
// - page fault when second operand is not a control-structure page
// - protection fault when target owner differs from second operand page
// - shared target, concurrent control page; busy target reports page conflict
// - atomic decrement; underflow leaves counter, sets flag, invalid-counter status
// - flag set on conflict or underflow, else cleared with status zero
// - distinct page-conflict status when another page op holds the page
`ifndef CHILD_COUNT_DECREMENT_LEAF_REGS_SVH
`define CHILD_COUNT_DECREMENT_LEAF_REGS_SVH

`define CDL_LEAF_DECREMENT   32'h0000_0000
`define CDL_CPL_KERNEL       2'h0
`define CDL_PAGE_OFFS_MASK   64'h0000_0000_0000_0FFF
`define CDL_PAGE_LAST        32'h0000_0FFF
`define CDL_VA_TOP_BIT       47
`define CDL_PT_CONTROL       3'h0
`define CDL_PT_THREAD        3'h1
`define CDL_PT_REGULAR       3'h2
`define CDL_PT_TRIMMED       3'h3
`define CDL_STATUS_OK        64'h0000_0000_0000_0000
`define CDL_STATUS_CONFLICT  64'h0000_0000_0000_0001
`define CDL_STATUS_INV_CNT   64'h0000_0000_0000_0002
`define CDL_PFEC_PROT_PAGE   32'h0000_8000
`define CDL_CNT_ZERO         64'h0000_0000_0000_0000
`define CDL_CNT_ONE          64'h0000_0000_0000_0001

`endif

// file: child_count_pkg.sv
// types of the child-page counter decrement leaf
// assumes the constants header sits in the include path
`include "child_count_decrement_leaf_regs.svh"
package child_count_pkg;
   typedef logic [63:0] addr_t;
   typedef logic [2:0]  ptype_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_XLAT_T, ST_XLAT_S, ST_CHECK, ST_CNT_RD, ST_CNT_WR, ST_DONE
   } leaf_state_e;

   typedef struct packed {
      leaf_state_e st;
      addr_t       lin_t;
      addr_t       lin_s;
      addr_t       t_phys;
      addr_t       t_owner;
      ptype_t      t_type;
      logic        t_valid;
      logic        t_busy;
      addr_t       s_phys;
      ptype_t      s_type;
      addr_t       cnt_wdata;
      logic        zf;
      addr_t       status;
      logic        gp;
      logic        pf;
      addr_t       pf_addr;
   } leaf_state_s;

   // upper bits must all repeat the top implemented bit
   function automatic logic is_canonical(input addr_t a);
      is_canonical = (&a[63:`CDL_VA_TOP_BIT]) || !(|a[63:`CDL_VA_TOP_BIT]);
   endfunction
endpackage

// file: operand_check.sv
// linear address forming and protection checks on both operands
// assumes segment state is stable while a request is offered
`timescale 1ns/1ns
`default_nettype none
`include "child_count_decrement_leaf_regs.svh"
module operand_check
   import child_count_pkg::*;
(
   input  wire logic                   i_mode64,
   input  wire child_count_pkg::addr_t i_ds_base,
   input  wire logic [31:0]            i_ds_limit,
   input  wire logic                   i_ds_unusable,
   input  wire child_count_pkg::addr_t i_first_operand_register,
   input  wire child_count_pkg::addr_t i_second_operand_register,
   output logic                        o_gp,
   output child_count_pkg::addr_t      o_lin_t,
   output child_count_pkg::addr_t      o_lin_s
);
   logic [32:0] end_t;
   logic [32:0] end_s;
   logic        limit_bad;

   always_comb begin
      if (i_mode64) begin
         o_lin_t = i_first_operand_register;
         o_lin_s = i_second_operand_register;
      end else begin
         o_lin_t = {32'h0000_0000, i_ds_base[31:0] + i_first_operand_register[31:0]};
         o_lin_s = {32'h0000_0000, i_ds_base[31:0] + i_second_operand_register[31:0]};
      end
      end_t = {1'b0, i_first_operand_register[31:0]} + {1'b0, `CDL_PAGE_LAST};
      end_s = {1'b0, i_second_operand_register[31:0]} + {1'b0, `CDL_PAGE_LAST};
      limit_bad = (end_t > {1'b0, i_ds_limit}) || (end_s > {1'b0, i_ds_limit});
      o_gp = 1'b0;
      if (!i_mode64 && (limit_bad || i_ds_unusable)) begin
         o_gp = 1'b1;
      end
      if (i_mode64 && !(is_canonical(i_first_operand_register)
                        && is_canonical(i_second_operand_register))) begin
         o_gp = 1'b1;
      end
      if ((i_first_operand_register & `CDL_PAGE_OFFS_MASK) != 64'h0) begin
         o_gp = 1'b1;
      end
   end
endmodule
`default_nettype wire

// file: child_count_decrement_leaf.sv
// child-page counter decrement leaf: checks, page lookups, locked decrement
// assumes a page lookup port and a locked counter port answering by ack
`timescale 1ns/1ns
`default_nettype none
`include "child_count_decrement_leaf_regs.svh"
module child_count_decrement_leaf
   import child_count_pkg::*;
(
   input  wire logic                    i_clk_sys,
   input  wire logic                    i_rst_n,
   input  wire logic                    i_req_valid,
   output logic                         o_req_ready,
   input  wire logic [31:0]             i_leaf_index,
   input  wire logic                    i_feature_en,
   input  wire logic [1:0]              i_cpl,
   input  wire logic                    i_mode64,
   input  wire logic                    i_seg_override,
   input  wire child_count_pkg::addr_t  i_ds_base,
   input  wire logic [31:0]             i_ds_limit,
   input  wire logic                    i_ds_unusable,
   input  wire child_count_pkg::addr_t  i_first_operand_register,
   input  wire child_count_pkg::addr_t  i_second_operand_register,
   output logic                         o_xlat_req,
   output child_count_pkg::addr_t       o_xlat_addr,
   output logic                         o_xlat_write,
   output logic                         o_xlat_enclave,
   input  wire logic                    i_xlat_ack,
   input  wire logic                    i_xlat_fault,
   input  wire logic                    i_xlat_in_cache,
   input  wire child_count_pkg::addr_t  i_xlat_phys,
   input  wire logic                    i_page_valid,
   input  wire child_count_pkg::ptype_t i_page_type,
   input  wire child_count_pkg::addr_t  i_page_owner,
   input  wire logic                    i_page_busy,
   output logic                         o_target_shared,
   output logic                         o_cnt_lock,
   output logic                         o_cnt_rd,
   output logic                         o_cnt_wr,
   output child_count_pkg::addr_t       o_cnt_addr,
   output child_count_pkg::addr_t       o_cnt_wdata,
   input  wire logic                    i_cnt_ack,
   input  wire child_count_pkg::addr_t  i_cnt_value,
   output logic                         o_done,
   output logic                         o_general_protection_fault,
   output logic                         o_page_fault,
   output child_count_pkg::addr_t       o_pf_addr,
   output logic [31:0]                  o_pf_error_code,
   output logic                         o_zero_result_flag,
   output child_count_pkg::addr_t       o_status_return_register
);
   leaf_state_s s_q;
   leaf_state_s s_d;
   logic        rst_meta_q;
   logic        rst_sync_n_q;
   logic        chk_gp;
   addr_t       lin_t;
   addr_t       lin_s;
   logic        taken;
   logic        type_ok;
   addr_t       owner;

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta_q   <= 1'b0;
         rst_sync_n_q <= 1'b0;
      end else begin
         rst_meta_q   <= 1'b1;
         rst_sync_n_q <= rst_meta_q;
      end
   end

   // segment overrides never reach the address path
   operand_check u_check (
      .i_mode64                  (i_mode64),
      .i_ds_base                 (i_ds_base),
      .i_ds_limit                (i_ds_limit),
      .i_ds_unusable             (i_ds_unusable),
      .i_first_operand_register  (i_first_operand_register),
      .i_second_operand_register (i_second_operand_register),
      .o_gp                      (chk_gp),
      .o_lin_t                   (lin_t),
      .o_lin_s                   (lin_s)
   );

   assign o_req_ready = (s_q.st == ST_IDLE);
   assign taken = i_req_valid && o_req_ready && i_feature_en
                  && (i_leaf_index == `CDL_LEAF_DECREMENT);

   always_comb begin
      // faults never touch flag or status
      s_d = s_q;
      type_ok = (s_q.t_type == `CDL_PT_REGULAR) || (s_q.t_type == `CDL_PT_THREAD)
                || (s_q.t_type == `CDL_PT_TRIMMED) || (s_q.t_type == `CDL_PT_CONTROL);
      owner = (s_q.t_type == `CDL_PT_CONTROL) ? s_q.t_phys : s_q.t_owner;
      case (s_q.st)
         ST_IDLE: begin
            if (taken) begin
               s_d.gp    = 1'b0;
               s_d.pf    = 1'b0;
               s_d.lin_t = lin_t;
               s_d.lin_s = lin_s;
               if (i_cpl != `CDL_CPL_KERNEL || chk_gp) begin
                  s_d.gp = 1'b1;
                  s_d.st = ST_DONE;
               end else begin
                  s_d.st = ST_XLAT_T;
               end
            end
         end
         ST_XLAT_T: begin
            if (i_xlat_ack) begin
               s_d.t_phys  = i_xlat_phys;
               s_d.t_owner = i_page_owner;
               s_d.t_type  = i_page_type;
               s_d.t_valid = i_page_valid;
               s_d.t_busy  = i_page_busy;
               if (i_xlat_fault || !i_xlat_in_cache) begin
                  s_d.pf      = 1'b1;
                  s_d.pf_addr = s_q.lin_t;
                  s_d.st      = ST_DONE;
               end else begin
                  s_d.st = ST_XLAT_S;
               end
            end
         end
         ST_XLAT_S: begin
            if (i_xlat_ack) begin
               s_d.s_phys = i_xlat_phys;
               s_d.s_type = i_page_type;
               if (i_xlat_fault || !i_xlat_in_cache) begin
                  s_d.pf      = 1'b1;
                  s_d.pf_addr = s_q.lin_s;
                  s_d.st      = ST_DONE;
               end else begin
                  s_d.st = ST_CHECK;
               end
            end
         end
         ST_CHECK: begin
            s_d.st = ST_DONE;
            if (s_q.t_busy) begin
               s_d.zf     = 1'b1;
               s_d.status = `CDL_STATUS_CONFLICT;
            end else if (!s_q.t_valid || !type_ok) begin
               s_d.pf      = 1'b1;
               s_d.pf_addr = s_q.lin_t;
            end else if (s_q.s_type != `CDL_PT_CONTROL) begin
               s_d.pf      = 1'b1;
               s_d.pf_addr = s_q.lin_s;
            end else if (owner != s_q.s_phys) begin
               s_d.gp = 1'b1;
            end else begin
               s_d.st = ST_CNT_RD;
            end
         end
         ST_CNT_RD: begin
            if (i_cnt_ack) begin
               if (i_cnt_value == `CDL_CNT_ZERO) begin
                  s_d.zf     = 1'b1;
                  s_d.status = `CDL_STATUS_INV_CNT;
                  s_d.st     = ST_DONE;
               end else begin
                  s_d.cnt_wdata = i_cnt_value - `CDL_CNT_ONE;
                  s_d.st        = ST_CNT_WR;
               end
            end
         end
         ST_CNT_WR: begin
            if (i_cnt_ack) begin
               s_d.zf     = 1'b0;
               s_d.status = `CDL_STATUS_OK;
               s_d.st     = ST_DONE;
            end
         end
         ST_DONE: begin
            s_d.st = ST_IDLE;
         end
         default: begin
            s_d.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge rst_sync_n_q) begin
      if (!rst_sync_n_q) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_xlat_req      = (s_q.st == ST_XLAT_T) || (s_q.st == ST_XLAT_S);
   assign o_xlat_addr     = (s_q.st == ST_XLAT_S) ? s_q.lin_s : s_q.lin_t;
   assign o_xlat_write    = (s_q.st == ST_XLAT_T);
   assign o_xlat_enclave  = (s_q.st == ST_XLAT_S);
   assign o_target_shared = (s_q.st != ST_IDLE) && (s_q.st != ST_DONE);
   assign o_cnt_lock      = (s_q.st == ST_CNT_RD) || (s_q.st == ST_CNT_WR);
   assign o_cnt_rd        = (s_q.st == ST_CNT_RD);
   assign o_cnt_wr        = (s_q.st == ST_CNT_WR);
   assign o_cnt_addr      = s_q.s_phys;
   assign o_cnt_wdata     = s_q.cnt_wdata;
   assign o_done          = (s_q.st == ST_DONE);
   assign o_general_protection_fault = o_done && s_q.gp;
   assign o_page_fault    = o_done && s_q.pf;
   assign o_pf_addr       = s_q.pf_addr;
   assign o_pf_error_code = s_q.pf ? `CDL_PFEC_PROT_PAGE : 32'h0000_0000;
   assign o_zero_result_flag       = s_q.zf;
   assign o_status_return_register = s_q.status;

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!rst_sync_n_q);

   sequence s_rd_ok;
      o_cnt_rd && i_cnt_ack && (i_cnt_value != `CDL_CNT_ZERO);
   endsequence
   sequence s_write_phase;
      o_cnt_wr && o_cnt_lock;
   endsequence

   a_cpl_refuse: assert property (
      taken && (i_cpl != `CDL_CPL_KERNEL) |=> o_done && o_general_protection_fault)
      else $error("non-kernel request not refused");
   a_leaf_select: assert property (
      i_req_valid && o_req_ready && (i_leaf_index != `CDL_LEAF_DECREMENT) |=> o_req_ready)
      else $error("other leaf index started the operation");
   a_addr_check: assert property (
      taken && (i_first_operand_register[11:0] != 12'h000) |=> o_general_protection_fault)
      else $error("misaligned target not faulted");
   a_xlat_fault: assert property (
      o_xlat_req && i_xlat_ack && i_xlat_fault
      |=> o_page_fault && (o_pf_addr == $past(o_xlat_addr)))
      else $error("translation fault not delivered as page fault");
   a_conflict_zf: assert property (
      (s_q.st == ST_CHECK) && s_q.t_busy
      |=> o_done && o_zero_result_flag && (o_status_return_register == `CDL_STATUS_CONFLICT)
          && !o_page_fault)
      else $error("busy target did not report conflict");
   a_underflow_status: assert property (
      o_cnt_rd && i_cnt_ack && (i_cnt_value == `CDL_CNT_ZERO)
      |=> o_done && !o_cnt_wr && o_zero_result_flag
          && (o_status_return_register == `CDL_STATUS_INV_CNT))
      else $error("underflow handled wrongly");
   a_dec_write: assert property (
      s_rd_ok |=> s_write_phase and (o_cnt_wdata == $past(i_cnt_value) - `CDL_CNT_ONE))
      else $error("decrement value wrong");
   a_success_flag: assert property (
      s_write_phase ##0 i_cnt_ack |=> o_done && !o_zero_result_flag
                                      && (o_status_return_register == `CDL_STATUS_OK))
      else $error("success did not clear flag");
   a_fault_keeps: assert property (
      o_done && (o_general_protection_fault || o_page_fault)
      |-> $stable(o_zero_result_flag) && $stable(o_status_return_register))
      else $error("fault changed flag or status");
endmodule
`default_nettype wire

// file: page_store_model.sv
// page lookup and locked counter store facing the decrement leaf
// assumes the leaf holds each request until it is acknowledged
`timescale 1ns/1ns
`default_nettype none
module page_store_model
   import child_count_pkg::*;
(
   input  wire logic                    i_clk_sys,
   input  wire logic                    i_rst_n,
   input  wire logic                    i_req,
   input  wire logic                    i_tgt,
   input  wire child_count_pkg::addr_t  i_addr,
   input  wire logic                    i_wr,
   input  wire child_count_pkg::addr_t  i_wdata,
   input  wire logic [1:0]              i_dly,
   input  wire logic [5:0]              i_cfg,
   input  wire child_count_pkg::ptype_t i_t_type,
   input  wire child_count_pkg::ptype_t i_s_type,
   input  wire child_count_pkg::addr_t  i_owner,
   input  wire logic                    i_load,
   input  wire child_count_pkg::addr_t  i_init,
   output logic                         o_ack,
   output logic                         o_fault,
   output logic                         o_in_cache,
   output child_count_pkg::addr_t       o_phys,
   output logic                         o_valid,
   output child_count_pkg::ptype_t      o_type,
   output child_count_pkg::addr_t       o_owner,
   output logic                         o_busy,
   output child_count_pkg::addr_t       o_value,
   output child_count_pkg::addr_t       o_cnt
);
   logic [1:0] w_q;
   logic       tog_q;
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         w_q <= 2'h0;
         o_ack <= 1'b0;
         tog_q <= 1'b0;
      end else begin
         tog_q <= !tog_q;
         o_ack <= i_req && !o_ack && (w_q == i_dly);
         w_q <= (i_req && !o_ack && (w_q != i_dly)) ? w_q + 2'h1 : 2'h0;
      end
   end
   always_ff @(posedge i_clk_sys) begin
      if (i_load) begin
         o_cnt <= i_init;
      end else if (o_ack && i_wr) begin
         o_cnt <= i_wdata;
      end
   end
   // lookup answers; lines toggle when idle
   // both fault bits on a target lookup: page outside the protected cache
   assign o_fault    = o_ack ? (i_tgt ? (i_cfg[4] && !i_cfg[3]) : i_cfg[3]) : tog_q;
   assign o_in_cache = o_ack ? !(i_tgt && i_cfg[4] && i_cfg[3]) : tog_q;
   assign o_phys     = o_ack ? i_addr : {64{tog_q}};
   assign o_valid    = o_ack ? (!i_tgt || !i_cfg[2]) : tog_q;
   assign o_type     = o_ack ? (i_tgt ? i_t_type : i_s_type) : {3{tog_q}};
   assign o_owner    = o_ack ? i_owner : {64{tog_q}};
   assign o_busy     = o_ack ? (i_tgt && i_cfg[1]) : tog_q;
   assign o_value    = o_ack ? o_cnt : {64{tog_q}};
endmodule
`default_nettype wire

// file: child_count_decrement_leaf_tb_top.sv
// self-checking bench of the child-page counter decrement leaf
// assumes the page store model answers lookups and counter accesses
`timescale 1ns/1ns
`default_nettype none
`include "child_count_decrement_leaf_regs.svh"
module child_count_decrement_leaf_tb_top;
   import child_count_pkg::*;
   localparam addr_t T = 64'h0000_0000_0020_0000;
   localparam addr_t S = 64'h0000_0000_0010_0000;
   typedef struct {
      logic [1:0] cpl;
      logic       m64;
      addr_t      first_operand_register;
      logic [5:0] fl;
      ptype_t     tt;
      ptype_t     st;
      addr_t      cnt;
      logic       gp;
      logic       pf;
   } row_s;
   logic i_clk_sys, i_rst_n, i_req_valid, i_feature_en, i_mode64, i_seg_override, i_ds_unusable;
   logic i_xlat_ack, i_xlat_fault, i_xlat_in_cache, i_page_valid, i_page_busy, i_cnt_ack;
   logic o_req_ready, o_xlat_req, o_xlat_write, o_xlat_enclave, o_target_shared, o_cnt_lock;
   logic o_cnt_rd, o_cnt_wr, o_done, o_general_protection_fault, o_page_fault, o_zero_result_flag;
   logic [31:0] i_leaf_index, i_ds_limit, o_pf_error_code;
   logic [1:0]  i_cpl, dly;
   logic [5:0]  cfg;
   ptype_t      i_page_type, t_type, s_type;
   addr_t       i_ds_base, i_first_operand_register, i_second_operand_register, i_xlat_phys;
   addr_t       i_page_owner, i_cnt_value, o_xlat_addr, o_cnt_addr, o_cnt_wdata, o_pf_addr;
   addr_t       o_status_return_register, owner, init, cnt_now, est;
   logic        ack, load, ezf;
   int          miscompares, cmp_count;
   // ordinary cases, fault rows expect counter unchanged
   row_s rows [18] = '{
      '{2'h0, 1'b1, T, 6'h00, 3'h2, 3'h0, 64'h5, 1'b0, 1'b0},
      '{2'h0, 1'b1, T, 6'h00, 3'h1, 3'h0, 64'h1, 1'b0, 1'b0},
      '{2'h0, 1'b0, T, 6'h00, 3'h3, 3'h0, 64'h3, 1'b0, 1'b0},
      '{2'h0, 1'b1, S, 6'h00, 3'h0, 3'h0, 64'h2, 1'b0, 1'b0},
      '{2'h0, 1'b1, T, 6'h00, 3'h2, 3'h0, 64'h0, 1'b0, 1'b0},
      '{2'h0, 1'b1, T, 6'h02, 3'h2, 3'h0, 64'h4, 1'b0, 1'b0},
      '{2'h3, 1'b1, T, 6'h00, 3'h2, 3'h0, 64'h7, 1'b1, 1'b0},
      '{2'h0, 1'b1, T + 64'h8, 6'h00, 3'h2, 3'h0, 64'h7, 1'b1, 1'b0},
      '{2'h0, 1'b1, 64'h0000_8000_0000_0000, 6'h00, 3'h2, 3'h0, 64'h7, 1'b1, 1'b0},
      '{2'h0, 1'b0, T, 6'h20, 3'h2, 3'h0, 64'h7, 1'b1, 1'b0},
      '{2'h0, 1'b0, 64'h0000_0000_0100_0000, 6'h00, 3'h2, 3'h0, 64'h7, 1'b1, 1'b0},
      '{2'h0, 1'b1, T, 6'h10, 3'h2, 3'h0, 64'h7, 1'b0, 1'b1},
      '{2'h0, 1'b1, T, 6'h08, 3'h2, 3'h0, 64'h7, 1'b0, 1'b1},
      '{2'h0, 1'b1, T, 6'h04, 3'h2, 3'h0, 64'h7, 1'b0, 1'b1},
      '{2'h0, 1'b1, T, 6'h00, 3'h4, 3'h0, 64'h7, 1'b0, 1'b1},
      '{2'h0, 1'b1, T, 6'h00, 3'h2, 3'h2, 64'h7, 1'b0, 1'b1},
      '{2'h0, 1'b1, T, 6'h01, 3'h2, 3'h0, 64'h7, 1'b1, 1'b0},
      '{2'h0, 1'b1, T, 6'h18, 3'h2, 3'h0, 64'h7, 1'b0, 1'b1}};

   child_count_decrement_leaf dut_u (.i_clk_sys, .i_rst_n, .i_req_valid, .o_req_ready,
      .i_leaf_index, .i_feature_en, .i_cpl, .i_mode64, .i_seg_override, .i_ds_base, .i_ds_limit,
      .i_ds_unusable, .i_first_operand_register, .i_second_operand_register, .o_xlat_req,
      .o_xlat_addr, .o_xlat_write, .o_xlat_enclave, .i_xlat_ack, .i_xlat_fault, .i_xlat_in_cache,
      .i_xlat_phys, .i_page_valid, .i_page_type, .i_page_owner, .i_page_busy, .o_target_shared,
      .o_cnt_lock, .o_cnt_rd, .o_cnt_wr, .o_cnt_addr, .o_cnt_wdata, .i_cnt_ack, .i_cnt_value,
      .o_done, .o_general_protection_fault, .o_page_fault, .o_pf_addr, .o_pf_error_code,
      .o_zero_result_flag, .o_status_return_register);

   page_store_model store_u (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
      .i_req(o_xlat_req | o_cnt_rd | o_cnt_wr), .i_tgt(o_xlat_write), .i_addr(o_xlat_addr),
      .i_wr(o_cnt_wr), .i_wdata(o_cnt_wdata), .i_dly(dly), .i_cfg(cfg), .i_t_type(t_type),
      .i_s_type(s_type), .i_owner(owner), .i_load(load), .i_init(init), .o_ack(ack),
      .o_fault(i_xlat_fault), .o_in_cache(i_xlat_in_cache), .o_phys(i_xlat_phys),
      .o_valid(i_page_valid), .o_type(i_page_type), .o_owner(i_page_owner),
      .o_busy(i_page_busy), .o_value(i_cnt_value), .o_cnt(cnt_now));
   assign i_xlat_ack = ack & o_xlat_req;
   assign i_cnt_ack  = ack & (o_cnt_rd | o_cnt_wr);

   task automatic chk(input addr_t seen, input addr_t exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic run(input row_s r, input logic [1:0] d);
      int n;
      @(negedge i_clk_sys);
      // target in first operand, control page in second
      i_first_operand_register = r.first_operand_register;
      i_cpl = r.cpl;
      i_mode64 = r.m64;
      i_ds_unusable = r.fl[5];
      cfg = r.fl;
      t_type = r.tt;
      s_type = r.st;
      owner = r.fl[0] ? S + 64'h1000 : S;
      dly = d;
      init = r.cnt;
      load = 1'b1;
      i_req_valid = 1'b1;
      @(negedge i_clk_sys);
      i_req_valid = 1'b0;
      load = 1'b0;
      n = 0;
      while (o_done !== 1'b1 && n < 200) begin
         @(negedge i_clk_sys);
         n++;
      end
      if (o_done !== 1'b1) begin
         miscompares++;
         end_of_test();
      end
      if (!(r.gp | r.pf)) begin
         ezf = r.fl[1] | (r.cnt == 64'h0);
         est = r.fl[1] ? `CDL_STATUS_CONFLICT
             : (r.cnt == 64'h0 ? `CDL_STATUS_INV_CNT : `CDL_STATUS_OK);
      end
      chk(o_general_protection_fault, r.gp);
      chk(o_page_fault, r.pf);
      if (r.pf) begin
         chk(o_pf_error_code, `CDL_PFEC_PROT_PAGE);
         chk(o_pf_addr, ((r.fl[3] && !r.fl[4]) || r.st != 3'h0) ? S : r.first_operand_register);
      end
      @(negedge i_clk_sys);
      chk(o_zero_result_flag, ezf);
      chk(o_status_return_register, est);
      chk(cnt_now, (r.gp | r.pf | ezf) ? r.cnt : r.cnt - 64'h1);
   endtask

   // each lookup is either target write or control enclave read
   always @(negedge i_clk_sys) begin
      if (i_xlat_ack === 1'b1) chk(o_xlat_write ^ o_xlat_enclave, 64'h1);
      if (i_xlat_ack === 1'b1) chk(o_xlat_addr, o_xlat_write ? i_first_operand_register
                                                   : i_second_operand_register);
      if (i_xlat_ack === 1'b1) chk(o_target_shared, 64'h1);
      if (i_cnt_ack === 1'b1) chk(o_cnt_addr, S);
      if (i_cnt_ack === 1'b1) chk(o_cnt_lock, 64'h1);
      if (i_cnt_ack === 1'b1) chk(o_target_shared, 64'h1);
   end

   initial begin
      i_clk_sys = 1'b0;
      forever #5 i_clk_sys = !i_clk_sys;
   end

   initial begin
      int n;
      {i_req_valid, i_seg_override, i_mode64, i_ds_unusable, load, ezf} = 6'h00;
      {i_cpl, dly, cfg, t_type, s_type} = 16'h0000;
      {owner, init, est, i_ds_base} = 256'h0;
      i_leaf_index = `CDL_LEAF_DECREMENT;
      i_feature_en = 1'b1;
      i_ds_limit = 32'h00FF_FFFF;
      i_first_operand_register = T;
      i_second_operand_register = S;
      i_rst_n = 1'b0;
      repeat (16) @(negedge i_clk_sys);
      i_rst_n = 1'b1;
      repeat (4) @(negedge i_clk_sys);
      // wrong leaf or feature clear is ignored
      i_req_valid = 1'b1;
      for (int k = 0; k < 2; k++) begin
         i_leaf_index = k ? 32'h0000_0001 : `CDL_LEAF_DECREMENT;
         i_feature_en = k[0];
         n = 0;
         repeat (12) begin
            @(negedge i_clk_sys);
            if (o_done === 1'b1) n++;
         end
         chk(n, 0);
         $display("test leaf refusal %0d ends", k);
      end
      i_req_valid = 1'b0;
      i_leaf_index = `CDL_LEAF_DECREMENT;
      i_feature_en = 1'b1;
      for (int i = 0; i < 18; i++) begin
         i_seg_override = i[0];
         run(rows[i], i[0] ? 2'h3 : 2'h0);
         $display("test row %0d ends", i);
      end
      // reset in mid-operation, then recovery
      @(negedge i_clk_sys);
      i_req_valid = 1'b1;
      repeat (3) @(negedge i_clk_sys);
      i_req_valid = 1'b0;
      i_rst_n = 1'b0;
      repeat (2) @(negedge i_clk_sys);
      i_rst_n = 1'b1;
      repeat (4) @(negedge i_clk_sys);
      chk(o_req_ready, 64'h1);
      chk(o_target_shared, 64'h0);
      chk(o_zero_result_flag, 64'h0);
      chk(o_status_return_register, `CDL_STATUS_OK);
      run(rows[0], 2'h1);
      $display("test mid reset ends");
      end_of_test();
   end
endmodule
`default_nettype wire
